// File: shared/cfpr_pkg.sv
// Constants for the nine-bit FIFO with parity, retransmit and cascade ring
`default_nettype none
package cfpr_pkg;
  localparam int          DATA_W      = 9;
  localparam int          ADDR_W      = 9;
  localparam int          DEPTH       = 512;
  // Bus register byte offsets
  localparam logic [3:0]  OFS_PROG    = 4'h0;
  localparam logic [3:0]  OFS_CONFIG  = 4'h4;
  localparam logic [3:0]  OFS_STATUS  = 4'h8;
  // Program word fields
  localparam int          PAR_EN_BIT  = 8;
  localparam int          PAR_CHK_BIT = 7;
  localparam int          PAR_ODD_BIT = 6;
  localparam logic [8:0]  PROG_RST    = 9'h000;
  // Config word fields
  localparam int          CFG_CASC    = 0;
  localparam int          CFG_PVIEW   = 1;
  localparam logic [1:0]  CFG_RST     = 2'h0;
  // Status word fields
  localparam int          ST_EMPTY    = 0;
  localparam int          ST_FULL     = 1;
  localparam int          ST_WTOK     = 2;
  localparam int          ST_RTOK     = 3;
  localparam int          ST_DRIVE    = 4;
  localparam int          ST_CNT_LSB  = 8;
  // Retransmit recovery, in ns, and derived cycles at 10 MHz
  localparam int          CLK_NS      = 100;
  localparam int          RTR_NS      = 100;
  localparam int          RTR_CYC_RAW = (RTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int          RTR_CYC     = (RTR_CYC_RAW < 1) ? 1 : RTR_CYC_RAW;
  localparam logic [3:0]  RTR_CNT     = 4'(RTR_CYC);
  // Retransmit sequence states, Gray along the path except the RT_RECV to RT_IDLE return
  typedef enum logic [1:0] {
    RT_IDLE = 2'b00,
    RT_HOLD = 2'b01,
    RT_RECV = 2'b11
  } cfpr_rt_t;
endpackage
`default_nettype wire

// File: core/cfpr_mem.sv
// Dual-port storage array with registered read data
`timescale 1ns/1ps
`default_nettype none
module cfpr_mem
  import cfpr_pkg::*;
(
  // Clock
  input  wire logic              clk_i,
  // Write port
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  // Read port
  input  wire logic              rd_en_i,
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [DATA_W-1:0] rd_data_o
);
  logic [DATA_W-1:0] store [DEPTH];

  // Array write; no reset so it maps onto block memory
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      store[wr_addr_i] <= wr_data_i;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk_i) begin
    if (rd_en_i) begin
      rd_data_o <= store[rd_addr_i];
    end
  end
endmodule // cfpr_mem
`default_nettype wire

// File: core/cfpr_fifo.sv
// FIFO core: parity options, retransmit, cascade ring and register slave
`timescale 1ns/1ps
`default_nettype none
module cfpr_fifo
  import cfpr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Writer side
  input  wire logic              write_enable_n_i,
  input  wire logic [DATA_W-1:0] data_i,
  // Reader side
  input  wire logic              read_enable_n_i,
  input  wire logic              output_enable_n_i,
  output logic      [DATA_W-1:0] data_o,
  output logic                   data_oe_o,
  // Retransmit
  input  wire logic              retransmit_n_i,
  // Cascade ring and strap
  input  wire logic              cascade_in_n_i,
  output logic                   cascade_out_n_o,
  input  wire logic              first_load_n_i,
  // Boundary flags
  output logic                   empty_o,
  output logic                   full_o
);
  // Pointer difference gives the fill level
  function automatic logic [ADDR_W:0] fill(input logic [ADDR_W:0] w, input logic [ADDR_W:0] r);
    fill = w - r;
  endfunction

  // Registers and state
  logic [8:0]        prog;
  logic [1:0]        cfg;
  logic [ADDR_W:0]   wr_ptr;
  logic [ADDR_W:0]   rd_ptr;
  logic              wtok;
  logic              rtok;
  logic              drive;
  logic              xo_n;
  cfpr_rt_t          rt_state;
  logic [3:0]        rt_cnt;
  logic              empty_q;
  logic              full_q;
  logic [31:0]       dat_q;
  logic              ack_q;
  logic [DATA_W-1:0] rd_data;

  logic [8:0]        next_prog;
  logic [1:0]        next_cfg;
  logic [ADDR_W:0]   next_wr_ptr;
  logic [ADDR_W:0]   next_rd_ptr;
  logic              next_wtok;
  logic              next_rtok;
  logic              next_drive;
  logic              next_xo_n;
  cfpr_rt_t          next_rt_state;
  logic [3:0]        next_rt_cnt;
  logic              next_empty;
  logic              next_full;
  logic [31:0]       next_dat;
  logic              next_ack;

  logic              cascaded;
  logic              bus_req;
  logic              rt_busy;
  logic              do_wr;
  logic              do_rd;
  logic [DATA_W-1:0] wr_word;
  logic [ADDR_W:0]   level;

  assign cascaded = cfg[CFG_CASC];
  assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_q;
  assign rt_busy  = (rt_state != RT_IDLE);
  assign level    = fill(wr_ptr, rd_ptr);

  // Accepted transfers; cascaded devices move only while holding the turn
  always_comb begin
    do_wr = ~write_enable_n_i & ~full_q & ~rt_busy & (~cascaded | wtok);
    do_rd = ~read_enable_n_i & ~empty_q & ~rt_busy & (~cascaded | rtok);
  end

  // Parity shaping of the stored ninth bit
  always_comb begin
    wr_word = data_i;
    if (prog[PAR_EN_BIT]) begin
      if (!prog[PAR_CHK_BIT]) begin
        wr_word[8] = (^data_i[7:0]) ^ prog[PAR_ODD_BIT];
      end else begin
        wr_word[8] = ((^data_i) == prog[PAR_ODD_BIT]);
      end
    end
  end

  cfpr_mem u_mem (
    .clk_i     (clk_i),
    .wr_en_i   (do_wr),
    .wr_addr_i (wr_ptr[ADDR_W-1:0]),
    .wr_data_i (wr_word),
    .rd_en_i   (do_rd),
    .rd_addr_i (rd_ptr[ADDR_W-1:0]),
    .rd_data_o (rd_data)
  );

  // Retransmit sequencer: low pulse, then recovery before new transfers
  always_comb begin
    next_rt_state = rt_state;
    next_rt_cnt   = rt_cnt;
    case (rt_state)
      RT_IDLE: begin
        if (!retransmit_n_i && !cascaded) begin
          next_rt_state = RT_HOLD;
        end
      end
      RT_HOLD: begin
        if (retransmit_n_i) begin
          next_rt_state = RT_RECV;
          next_rt_cnt   = RTR_CNT;
        end
      end
      RT_RECV: begin
        // Guards a controller that re-enables too early
        if (rt_cnt <= 4'h1) begin
          next_rt_state = RT_IDLE;
          next_rt_cnt   = 4'h0;
        end else begin
          next_rt_cnt = rt_cnt - 4'h1;
        end
      end
      default: begin
        next_rt_state = RT_IDLE;
        next_rt_cnt   = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rt_state <= RT_IDLE;
      rt_cnt   <= 4'h0;
    end else begin
      rt_state <= next_rt_state;
      rt_cnt   <= next_rt_cnt;
    end
  end

  // Pointers and boundary flags; flags follow pointers every cycle
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (do_wr) begin
      next_wr_ptr = wr_ptr + 10'h001;
    end
    if (rt_state == RT_IDLE && !retransmit_n_i && !cascaded) begin
      next_rd_ptr = '0;
    end else if (do_rd) begin
      next_rd_ptr = rd_ptr + 10'h001;
    end
    // One clock, so a read right after the first write is always counted
    next_empty = (fill(next_wr_ptr, next_rd_ptr) == 10'h000);
    next_full  = (fill(next_wr_ptr, next_rd_ptr) == 10'(DEPTH));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      empty_q <= 1'b1;
      full_q  <= 1'b0;
    end else begin
      wr_ptr  <= next_wr_ptr;
      rd_ptr  <= next_rd_ptr;
      empty_q <= next_empty;
      full_q  <= next_full;
    end
  end

  // Cascade turns: one handoff pulse per departing write or read turn
  always_comb begin
    next_wtok  = wtok;
    next_rtok  = rtok;
    next_drive = drive;
    next_xo_n  = 1'b1;
    if (cascaded) begin
      if (do_wr && next_full) begin
        next_wtok = 1'b0;
        next_xo_n = 1'b0;
      end else if (do_rd && next_empty && !wtok) begin
        next_rtok = 1'b0;
        next_xo_n = 1'b0;
      end
      // Incoming pulse: an empty idle device takes the write turn first
      if (!cascade_in_n_i) begin
        if (empty_q && !wtok && !rtok) begin
          next_wtok = 1'b1;
        end else if (!empty_q && !rtok) begin
          next_rtok = 1'b1;
        end
      end
    end
    // Bus released on the edge after handing off, driven after first read
    if (cascaded && !rtok) begin
      next_drive = 1'b0;
    end else if (do_rd) begin
      next_drive = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wtok  <= ~first_load_n_i;
      rtok  <= ~first_load_n_i;
      drive <= 1'b0;
      xo_n  <= 1'b1;
    end else begin
      wtok  <= next_wtok;
      rtok  <= next_rtok;
      drive <= next_drive;
      xo_n  <= next_xo_n;
    end
  end

  // Register slave; unmapped reads give zero, unmapped writes are dropped
  always_comb begin
    next_prog = prog;
    next_cfg  = cfg;
    next_ack  = bus_req;
    next_dat  = 32'h0000_0000;
    if (bus_req && wb_we_i) begin
      case (wb_adr_i)
        OFS_PROG: begin
          if (wb_sel_i[0]) begin
            next_prog[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            next_prog[8] = wb_dat_i[8];
          end
          // Almost-flag settings mean nothing in a cascade
          if (cascaded) begin
            next_prog[5:0] = prog[5:0];
          end
        end
        OFS_CONFIG: begin
          if (wb_sel_i[0]) begin
            next_cfg = wb_dat_i[1:0];
          end
        end
        default: begin
          next_cfg = cfg;
        end
      endcase
    end else if (bus_req) begin
      case (wb_adr_i)
        OFS_PROG:   next_dat = {23'h000000, prog};
        OFS_CONFIG: next_dat = {30'h00000000, cfg};
        OFS_STATUS: next_dat = {14'h0000, level, 3'h0, drive, rtok, wtok, full_q, empty_q};
        default:    next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog  <= PROG_RST;
      cfg   <= CFG_RST;
      dat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      prog  <= next_prog;
      cfg   <= next_cfg;
      dat_q <= next_dat;
      ack_q <= next_ack;
    end
  end

  // Outputs; bit 8 carries data, generated parity or parity match flag, or the parity enable bit in program view
  always_comb begin
    wb_dat_o        = dat_q;
    wb_ack_o        = ack_q;
    cascade_out_n_o = xo_n;
    empty_o         = empty_q;
    full_o          = full_q;
    if (cfg[CFG_PVIEW]) begin
      data_o    = prog;
      data_oe_o = ~output_enable_n_i & (~cascaded | ~first_load_n_i);
    end else begin
      data_o    = rd_data;
      data_oe_o = ~output_enable_n_i & (~cascaded | drive);
    end
  end
endmodule // cfpr_fifo
`default_nettype wire

// File: verification/cfpr_fifo_properties.sv
// Port-level assertions for the parity and retransmit FIFO
`timescale 1ns/1ps
`default_nettype none
module cfpr_fifo_properties (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus handshake
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // FIFO side
  input wire logic        write_enable_n_i,
  input wire logic        output_enable_n_i,
  input wire logic        data_oe_o,
  input wire logic        retransmit_n_i,
  input wire logic        cascade_out_n_o,
  input wire logic        empty_o,
  input wire logic        full_o
);
  // One clock domain, so clocking and disable are shared
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_resp;  wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_dat_idle;  !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_ring_pulse; !cascade_out_n_o |=> cascade_out_n_o; endproperty
  property p_oe_gate;   output_enable_n_i |-> !data_oe_o; endproperty
  property p_empty_hold; empty_o && write_enable_n_i && retransmit_n_i |=> empty_o; endproperty
  property p_full_hold; !full_o && write_enable_n_i && retransmit_n_i |=> !full_o; endproperty
  property p_flag_excl; !(empty_o && full_o); endproperty
  a_ack_resp:   assert property (p_ack_resp) else $error("no ack after request");
  a_ack_pulse:  assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_dat_idle:   assert property (p_dat_idle) else $error("read data outside ack");
  a_ring_pulse: assert property (p_ring_pulse) else $error("cascade out too long");
  a_oe_gate:    assert property (p_oe_gate) else $error("driving while disabled");
  a_empty_hold: assert property (p_empty_hold) else $error("empty lost without write");
  a_full_hold:  assert property (p_full_hold) else $error("full without write");
  a_flag_excl:  assert property (p_flag_excl) else $error("empty and full together");
  // Main scenarios reached
  c_ring:  cover property (!cascade_out_n_o);
  c_retx:  cover property (!retransmit_n_i ##1 retransmit_n_i);
  c_full:  cover property (full_o);
endmodule // cfpr_fifo_properties
bind cfpr_fifo cfpr_fifo_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .write_enable_n_i(write_enable_n_i),
  .output_enable_n_i(output_enable_n_i), .data_oe_o(data_oe_o),
  .retransmit_n_i(retransmit_n_i), .cascade_out_n_o(cascade_out_n_o),
  .empty_o(empty_o), .full_o(full_o)
);
`default_nettype wire

// File: verification/cfpr_peer.sv
// Writer and reader model driving the clocked enables
`timescale 1ns/1ps
`default_nettype none
module cfpr_peer
  import cfpr_pkg::*;
(
  // Clock and bench requests
  input  wire logic              clk_i,
  input  wire logic              wr_req_i,
  input  wire logic [DATA_W-1:0] wr_word_i,
  input  wire logic              rd_req_i,
  // Toward the FIFO
  output logic                   write_enable_n_o,
  output logic      [DATA_W-1:0] data_o,
  output logic                   read_enable_n_o
);
  // Idle at time zero so nothing is taken during reset
  initial begin
    write_enable_n_o = 1'b1;
    read_enable_n_o  = 1'b1;
    data_o           = '0;
  end
  // Enables move just after an edge; idle data inverted so stale words never match
  always @(posedge clk_i) begin
    write_enable_n_o <= !wr_req_i;
    data_o           <= wr_req_i ? wr_word_i : ~data_o;
    read_enable_n_o  <= !rd_req_i;
  end
endmodule // cfpr_peer
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench: parity options, retransmit, cascade ring, registers
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cfpr_pkg::*;
;
  // Clock, reset and bus
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc = 1'b0;
  logic              we = 1'b0;
  logic [3:0]        adr = 4'h0;
  logic [31:0]       wdat = 32'h0;
  logic [31:0]       rdat;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  // FIFO side
  logic              wr_req = 1'b0;
  logic              rd_req = 1'b0;
  logic              oe_n = 1'b0;
  logic              retx_n = 1'b1;
  logic              fl_n = 1'b0;
  logic [DATA_W-1:0] wr_word = '0;
  logic [DATA_W-1:0] pdat;
  logic [DATA_W-1:0] data_o;
  logic              wen_n, ren_n, data_oe_o, ring_n, empty_o, full_o;
  int                num_errors = 0;
  int                samples_checked = 0;
  int                seed = 32'h8f97ac05;
  int                i;
  logic [DATA_W-1:0] w [4];
  logic [2:0]        modes [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  // Free-running 10 MHz clock
  always #50 clk_i = ~clk_i;
  // Single device closes the ring on itself, strapped first
  cfpr_fifo DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .write_enable_n_i(wen_n), .data_i(pdat), .read_enable_n_i(ren_n),
    .output_enable_n_i(oe_n), .data_o(data_o), .data_oe_o(data_oe_o),
    .retransmit_n_i(retx_n), .cascade_in_n_i(ring_n), .cascade_out_n_o(ring_n),
    .first_load_n_i(fl_n), .empty_o(empty_o), .full_o(full_o));
  cfpr_peer u_peer (.clk_i(clk_i), .wr_req_i(wr_req), .wr_word_i(wr_word), .rd_req_i(rd_req),
    .write_enable_n_o(wen_n), .data_o(pdat), .read_enable_n_o(ren_n));
  task automatic results;
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp_reg(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp_word(string n, logic [8:0] e, logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  // Classic single cycle; read data taken at the ack edge
  task automatic wb(logic wr, logic [3:0] a, logic [31:0] d);
    int t;
    cyc  <= 1'b1;
    we   <= wr;
    adr  <= a;
    wdat <= d;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    rdat = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      results;
    end
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  // Two cycles per word keeps the request strobe from being set twice in one step
  task automatic push(logic [8:0] d);
    wr_req  <= 1'b1;
    wr_word <= d;
    @(posedge clk_i);
    wr_req <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pop(logic [8:0] e);
    rd_req <= 1'b1;
    @(posedge clk_i);
    rd_req <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    cmp_word("data_o", e, data_o);
    @(posedge clk_i);
  endtask
  // Enables stay idle through the pulse and recovery
  task automatic retx;
    retx_n <= 1'b0;
    @(posedge clk_i);
    retx_n <= 1'b1;
    repeat (RTR_CYC + 1) @(posedge clk_i);
  endtask
  // Ninth bit from the ones count: generate sets the total, check flags a match
  function automatic logic [8:0] exp_word(logic [2:0] md, logic [8:0] d);
    if (!md[2])
      return d;
    if (!md[1])
      return {(($countones(d[7:0]) % 2) == 0) ? md[0] : !md[0], d[7:0]};
    return {($countones(d) % 2) == int'(md[0]), d[7:0]};
  endfunction
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OFS_STATUS, 32'h0);
    cmp_reg("status", 32'hd, rdat & 32'h7ff1f);
    wb(1'b0, 4'hc, 32'h0);
    cmp_reg("unmapped", 32'h0, rdat);
    foreach (modes[k]) begin
      wb(1'b1, OFS_PROG, {23'h0, modes[k], 6'h2a});
      wb(1'b0, OFS_PROG, 32'h0);
      cmp_reg("prog", {23'h0, modes[k], 6'h2a}, rdat);
      for (i = 0; i < 4; i++) begin
        // Second word differs only in bit 8: check mode sees a match and an error
        w[i] = (i == 1) ? (w[0] ^ 9'h100) : 9'($random(seed));
        push(w[i]);
      end
      for (i = 0; i < 4; i++) pop(exp_word(modes[k], w[i]));
    end
    cmp_reg("data_oe_o", 32'h1, {31'h0, data_oe_o});
    oe_n <= 1'b1;
    @(negedge clk_i);
    cmp_reg("data_oe_o", 32'h0, {31'h0, data_oe_o});
    @(posedge clk_i);
    oe_n <= 1'b0;
    // Mid-run resets: a non-first strap starts with no turns, then restart as first
    fl_n  <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OFS_STATUS, 32'h0);
    cmp_reg("status", 32'h1, rdat & 32'h7ff1f);
    fl_n  <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Replay starts at location zero, so the packet must begin there
    wb(1'b1, OFS_PROG, 32'h2a);
    for (i = 0; i < 3; i++) begin
      w[i] = 9'($random(seed));
      push(w[i]);
    end
    pop(w[0]);
    pop(w[1]);
    retx;
    cmp_reg("empty_o", 32'h0, {31'h0, empty_o});
    w[3] = 9'h1ff;
    push(w[3]);
    for (i = 0; i < 4; i++) pop(w[i]);
    retx;
    for (i = 0; i < 4; i++) pop(w[i]);
    cmp_reg("empty_o", 32'h1, {31'h0, empty_o});
    wb(1'b1, OFS_CONFIG, 32'h3);
    @(negedge clk_i);
    cmp_word("prog view", 9'h02a, data_o);
    cmp_reg("data_oe_o", 32'h1, {31'h0, data_oe_o});
    @(posedge clk_i);
    fl_n <= 1'b1;
    @(negedge clk_i);
    cmp_reg("data_oe_o", 32'h0, {31'h0, data_oe_o});
    @(posedge clk_i);
    fl_n <= 1'b0;
    wb(1'b1, OFS_CONFIG, 32'h1);
    push(9'h055);
    push(9'h0aa);
    pop(9'h055);
    retx;
    pop(9'h0aa);
    for (i = 0; i < DEPTH; i++) push(9'(i));
    @(negedge clk_i);
    cmp_reg("full_o", 32'h1, {31'h0, full_o});
    @(posedge clk_i);
    for (i = 0; i < DEPTH; i++) pop(9'(i));
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    cmp_reg("data_oe_o", 32'h0, {31'h0, data_oe_o});
    // Handoff looped back: empty device holds the write turn only
    @(posedge clk_i);
    wb(1'b0, OFS_STATUS, 32'h0);
    cmp_reg("status", 32'h5, rdat & 32'h7ff1f);
    results;
  end
endmodule // testbench
`default_nettype wire
